/* rtl/acs_map.vh */
// register map, field positions and source codes for the channel input select block
// What this block does
// RULE1: bits 15-11 and 7-3 of the select register always read zero.
// RULE2: mux b negative select bits 10-9: 11 inputs 9/10/11, 10 amp3-or-6/7/8, 0x low reference.
// RULE3: mux b positive bit 8: set amp1-or-3/amp2-or-0/amp3-or-6, clear amp2-or-0/1/2.
// RULE4: mux a negative select bits 2-1 uses the same encoding as mux b negative.
// RULE5: in twelve bit mode all select fields read back as zero.
// RULE6: amplifier-or-pin source picks amplifier output when its enable is one, else pin.
// RULE7: mux b selections apply while alternate active, else mux a; bit 0 stored read-write.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// apb register byte address
`define ACS_ADDR_SELECT 12'h000
`define ACS_ADDR_W 12
// field positions
`define ACS_NB_HI 10
`define ACS_NB_LO 9
`define ACS_SB_BIT 8
`define ACS_NA_HI 2
`define ACS_NA_LO 1
`define ACS_SA_BIT 0
`define ACS_RESET_VAL 16'h0000
// negative select codes
`define ACS_NEG_PINS_HI 2'h3
`define ACS_NEG_AMP3 2'h2
// source codes on the channel outputs
`define ACS_SRC_W 5
`define ACS_SRC_AN0 5'h00
`define ACS_SRC_AN1 5'h01
`define ACS_SRC_AN2 5'h02
`define ACS_SRC_AN3 5'h03
`define ACS_SRC_AN6 5'h06
`define ACS_SRC_AN7 5'h07
`define ACS_SRC_AN8 5'h08
`define ACS_SRC_AN9 5'h09
`define ACS_SRC_ANALOG_INPUT_10 5'h0a
`define ACS_SRC_ANALOG_INPUT_11 5'h0b
`define ACS_SRC_AMP1 5'h11
`define ACS_SRC_AMP2 5'h12
`define ACS_SRC_AMP3 5'h13
`define ACS_SRC_LOW_REFERENCE 5'h1f

`endif

/* rtl/acs_route.v */
// registered channel source router for channels 1 to 3
`timescale 1ns/1ns
`include "acs_map.vh"
module acs_route (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // selection in
  input wire [1:0] neg_sel,
  input wire pos_sel,
  input wire [2:0] amplifier_enable,
  // sources out
  output reg [14:0] pos_src,
  output reg [14:0] neg_src
);

  // amplifier-or-pin pick
  function [4:0] amp_or_pin;
    input en;
    input [4:0] amp;
    input [4:0] pin;
    begin
      amp_or_pin = en ? amp : pin; // RULE6
    end
  endfunction

  reg [14:0] pos_next;
  reg [14:0] neg_next;

  // decode selections, ch3 in high bits
  always @* begin
    if (pos_sel) begin // RULE3
      pos_next = {amp_or_pin(amplifier_enable[2], `ACS_SRC_AMP3, `ACS_SRC_AN6),
                  amp_or_pin(amplifier_enable[1], `ACS_SRC_AMP2, `ACS_SRC_AN0),
                  amp_or_pin(amplifier_enable[0], `ACS_SRC_AMP1, `ACS_SRC_AN3)};
    end else begin
      pos_next = {`ACS_SRC_AN2, `ACS_SRC_AN1,
                  amp_or_pin(amplifier_enable[1], `ACS_SRC_AMP2, `ACS_SRC_AN0)};
    end
    case (neg_sel) // RULE2 RULE4
      `ACS_NEG_PINS_HI: neg_next = {`ACS_SRC_ANALOG_INPUT_11, `ACS_SRC_ANALOG_INPUT_10, `ACS_SRC_AN9};
      `ACS_NEG_AMP3: neg_next = {`ACS_SRC_AN8, `ACS_SRC_AN7,
                                 amp_or_pin(amplifier_enable[2], `ACS_SRC_AMP3,
                                 `ACS_SRC_AN6)};
      default: neg_next = {`ACS_SRC_LOW_REFERENCE, `ACS_SRC_LOW_REFERENCE, `ACS_SRC_LOW_REFERENCE};
    endcase
  end

  // output registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_src <= {3{`ACS_SRC_AN0}};
      neg_src <= {3{`ACS_SRC_LOW_REFERENCE}};
    end else begin
      pos_src <= pos_next;
      neg_src <= neg_next;
    end
  end

endmodule // acs_route

/* rtl/acs_top.v */
// apb register and mux a/b selection for converter channels 1 to 3
`timescale 1ns/1ns
`include "acs_map.vh"
module acs_top (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // converter state
  input wire twelve_bit_mode,
  input wire sample_multiplexer_alternate,
  input wire [2:0] amplifier_enable,
  // channel sources, 5 bits per channel, ch1 lowest
  output wire [14:0] ch123_pos_source,
  output wire [14:0] ch123_neg_source
);

  // --------------------------------
  // reset values of the stored fields
  // --------------------------------
  // cut from the whole register value so a new reset value needs one edit
  localparam [15:0] RESET_VAL = `ACS_RESET_VAL;
  localparam [1:0] NB_RESET = RESET_VAL[`ACS_NB_HI:`ACS_NB_LO];
  localparam [0:0] SB_RESET = RESET_VAL[`ACS_SB_BIT];
  localparam [1:0] NA_RESET = RESET_VAL[`ACS_NA_HI:`ACS_NA_LO];
  localparam [0:0] SA_RESET = RESET_VAL[`ACS_SA_BIT];

  // --------------------------------
  // helpers
  // --------------------------------

  // true when the address names the select register
  function addr_hit;
    input [11:0] addr;
    begin
      addr_hit = (addr == `ACS_ADDR_SELECT);
    end
  endfunction

  // hide a two bit field while twelve bit mode is on
  function [1:0] hide2;
    input twelve;
    input [1:0] val;
    begin
      hide2 = twelve ? 2'h0 : val; // RULE5
    end
  endfunction

  // hide a one bit field while twelve bit mode is on
  function hide1;
    input twelve;
    input val;
    begin
      hide1 = twelve ? 1'b0 : val; // RULE5
    end
  endfunction

  // pick the field of the multiplexer now sampling
  function [1:0] pick2;
    input alt;
    input [1:0] b_val;
    input [1:0] a_val;
    begin
      pick2 = alt ? b_val : a_val; // RULE7
    end
  endfunction

  // --------------------------------
  // bus decode
  // --------------------------------
  wire hit;
  wire setup_phase;
  wire access_phase;
  wire wr_en;
  wire wr_lane1;
  wire wr_lane0;
  wire rd_setup;

  // address match and phase qualifiers
  assign hit = addr_hit(paddr);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_en = access_phase & pwrite & hit;
  assign wr_lane1 = wr_en & pstrb[1];
  assign wr_lane0 = wr_en & pstrb[0];
  assign rd_setup = setup_phase & ~pwrite;

  // no wait states; an error only for an unmapped address
  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit;

  // --------------------------------
  // select register
  // --------------------------------
  reg [1:0] neg_select_mux_b_reg;
  reg [1:0] neg_select_mux_b_next;
  reg pos_select_mux_b_reg;
  reg pos_select_mux_b_next;
  reg [1:0] neg_select_mux_a_reg;
  reg [1:0] neg_select_mux_a_next;
  reg pos_select_mux_a_reg;
  reg pos_select_mux_a_next;

  // next values; lane 1 holds the b fields, lane 0 the a fields
  always @* begin
    neg_select_mux_b_next = neg_select_mux_b_reg;
    pos_select_mux_b_next = pos_select_mux_b_reg;
    neg_select_mux_a_next = neg_select_mux_a_reg;
    pos_select_mux_a_next = pos_select_mux_a_reg;
    if (wr_lane1) begin
      neg_select_mux_b_next = pwdata[`ACS_NB_HI:`ACS_NB_LO]; // RULE2
      pos_select_mux_b_next = pwdata[`ACS_SB_BIT]; // RULE3
    end
    if (wr_lane0) begin
      neg_select_mux_a_next = pwdata[`ACS_NA_HI:`ACS_NA_LO]; // RULE4
      pos_select_mux_a_next = pwdata[`ACS_SA_BIT]; // RULE7
    end
  end

  // stored fields; writes in twelve bit mode still land
  // so a setup written in that mode applies when that mode is left
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_select_mux_b_reg <= NB_RESET;
      pos_select_mux_b_reg <= SB_RESET;
      neg_select_mux_a_reg <= NA_RESET;
      pos_select_mux_a_reg <= SA_RESET;
    end else begin
      neg_select_mux_b_reg <= neg_select_mux_b_next;
      pos_select_mux_b_reg <= pos_select_mux_b_next;
      neg_select_mux_a_reg <= neg_select_mux_a_next;
      pos_select_mux_a_reg <= pos_select_mux_a_next;
    end
  end

  // --------------------------------
  // read path
  // --------------------------------
  wire [1:0] neg_b_vis;
  wire pos_b_vis;
  wire [1:0] neg_a_vis;
  wire pos_a_vis;
  wire [15:0] rd_val;
  reg [31:0] prdata_next;

  // fields as software sees them
  assign neg_b_vis = hide2(twelve_bit_mode, neg_select_mux_b_reg); // RULE5
  assign pos_b_vis = hide1(twelve_bit_mode, pos_select_mux_b_reg); // RULE5
  assign neg_a_vis = hide2(twelve_bit_mode, neg_select_mux_a_reg); // RULE5
  assign pos_a_vis = hide1(twelve_bit_mode, pos_select_mux_a_reg); // RULE5

  // unused bits read zero
  assign rd_val = {5'h00, neg_b_vis, pos_b_vis, 5'h00, neg_a_vis, pos_a_vis}; // RULE1

  // read data loads in the setup phase so it stands through access
  always @* begin
    prdata_next = prdata;
    if (rd_setup) begin
      prdata_next = hit ? {16'h0000, rd_val} : 32'h00000000;
    end
  end

  // registered read data, held until the next read setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_next;
    end
  end

  // --------------------------------
  // routing
  // --------------------------------
  wire [1:0] neg_active;
  wire [1:0] pos_active;
  wire [1:0] neg_eff;
  wire pos_eff;

  // mux b fields apply only while the alternate multiplexer samples
  assign neg_active = pick2(sample_multiplexer_alternate, neg_select_mux_b_reg,
    neg_select_mux_a_reg); // RULE7
  assign pos_active = pick2(sample_multiplexer_alternate, {1'b0, pos_select_mux_b_reg},
    {1'b0, pos_select_mux_a_reg}); // RULE7

  // twelve bit mode has no select fields and routes as code zero
  assign neg_eff = hide2(twelve_bit_mode, neg_active); // RULE5
  assign pos_eff = hide1(twelve_bit_mode, pos_active[0]); // RULE5

  // the router registers its outputs, so sources follow one edge late
  acs_route u_route (
    .pclk(pclk),
    .presetn(presetn),
    .neg_sel(neg_eff),
    .pos_sel(pos_eff),
    .amplifier_enable(amplifier_enable),
    .pos_src(ch123_pos_source),
    .neg_src(ch123_neg_source)
  );

endmodule // acs_top

/* verif/acs_top_properties.sv */
// assertions for the channel input select block
`timescale 1ns/1ns
module acs_top_properties (
  // watched ports
  input logic pclk, presetn, psel, penable, pwrite, twelve_bit_mode,
  input logic sample_multiplexer_alternate,
  input logic [11:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [3:0] pstrb,
  input logic [2:0] amplifier_enable,
  input logic [14:0] ch123_pos_source, ch123_neg_source
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup, read access, full write
  wire rs = psel & !penable & !pwrite;
  wire rd = psel & penable & !pwrite;
  wire wr = psel & penable & pwrite & paddr == 12'h000 & pstrb[1] & pstrb[0];
  wire nt = !twelve_bit_mode;
  chk_rsvd_zero: assert property (rd |-> (prdata & 32'hffff_f8f8) == 0)
    else $error("reserved bits set");
  chk_twelve_read: assert property (rs & !nt |=> prdata == 0)
    else $error("twelve read");
  chk_twelve_src: assert property ($past(twelve_bit_mode) |-> ch123_neg_source == 15'h7fff)
    else $error("twelve source");
  chk_neg_legal: assert property (ch123_neg_source inside {15'h7fff, 15'h2d49, 15'h20f3, 15'h20e6})
    else $error("neg code");
  chk_pos_clear: assert property (ch123_pos_source[9:5] == 5'h01 |-> ch123_pos_source[14:10] == 5'h02)
    else $error("pos clear");
  chk_amp_pick: assert property (ch123_neg_source[14:10] == 5'h08 |-> ch123_neg_source[4:0] == ($past(amplifier_enable[2]) ? 5'h13 : 5'h06))
    else $error("amp pick");
  chk_mux_a: assert property (wr & pwdata[2:1] == 2'h3 ##1 !sample_multiplexer_alternate & nt |=> ch123_neg_source == 15'h2d49)
    else $error("mux a");
  chk_mux_b: assert property (wr & pwdata[10:9] == 2'h3 ##1 sample_multiplexer_alternate & nt |=> ch123_neg_source == 15'h2d49)
    else $error("mux b");
  cover property (rd & !nt);
  cover property (ch123_neg_source == 15'h20f3);
  cover property (ch123_pos_source[4:0] == 5'h11);
endmodule // acs_top_properties

/* verif/acs_top_tb.sv */
// bench for the channel input select block
`timescale 1ns/1ns
module acs_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tw = 0, alt = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r, d;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] en = 0;
  logic [1:0] c;
  logic s;
  wire pready, pslverr;
  wire [31:0] prdata;
  wire [14:0] ps, ns;
  integer n_errors = 0, check_count = 0, k, i;
  always #20 pclk = ~pclk;
  acs_top dut_u (.*, .twelve_bit_mode(tw), .sample_multiplexer_alternate(alt),
    .amplifier_enable(en), .ch123_pos_source(ps), .ch123_neg_source(ns));
  task stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cmp(input [31:0] g, e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, bounded wait on pready
  task xfer(input [11:0] a, input [31:0] wd, input w);
    psel <= 1;
    paddr <= a;
    pwdata <= wd;
    pwrite <= w;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (i = 0; pready !== 1'b1; i++) begin
      if (i == 9) begin
        n_errors++;
        stop_test;
      end
      @(posedge pclk);
    end
    r = prdata;
    s = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // expected sources from code and amplifier enables
  function [14:0] xn(input [1:0] v);
    xn = v == 2'h3 ? 15'h2d49 : v == 2'h2 ? (en[2] ? 15'h20f3 : 15'h20e6) : 15'h7fff;
  endfunction
  function [14:0] xp(input v);
    xp = v ? {en[2] ? 5'h13 : 5'h06, en[1] ? 5'h12 : 5'h00, en[0] ? 5'h11 : 5'h03}
      : {5'h02, 5'h01, en[1] ? 5'h12 : 5'h00};
  endfunction
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(12'h000, 0, 0);
    cmp(r, 0);
    cmp(s, 0);
    xfer(12'h000, 32'hffff_ffff, 1);
    xfer(12'h000, 0, 0);
    cmp(r, 32'h0000_0707);
    xfer(12'h004, 0, 0);
    cmp(r, 0);
    cmp(s, 1);
    // unmapped write is ignored
    xfer(12'h004, 0, 1);
    cmp(s, 1);
    xfer(12'h000, 0, 0);
    cmp(r, 32'h0000_0707);
    // lane 0 alone clears only the mux a fields
    pstrb <= 4'h1;
    xfer(12'h000, 0, 1);
    pstrb <= 4'hf;
    xfer(12'h000, 0, 0);
    cmp(r, 32'h0000_0700);
    // active field gets the code, idle field its inverse
    for (k = 0; k < 32; k++) begin
      c = k[1:0];
      alt <= k[4];
      en <= k[3] ? 3'h5 : 3'h2;
      d = k[4] ? {c, k[2], 5'h00, ~c, ~k[2]} : {~c, ~k[2], 5'h00, c, k[2]};
      xfer(12'h000, d, 1);
      repeat (3) @(posedge pclk);
      cmp(ns, xn(c));
      cmp(ps, xp(k[2]));
    end
    tw <= 1;
    xfer(12'h000, 0, 0);
    cmp(r, 0);
    repeat (3) @(posedge pclk);
    cmp(ns, 15'h7fff);
    cmp(ps, xp(0));
    tw <= 0;
    xfer(12'h000, 0, 0);
    cmp(r, d);
    stop_test;
  end
endmodule // acs_top_tb
bind acs_top acs_top_properties chk_u (.*);
